// *** logic/eis_consts.svh ***
// Constants for the Ethernet interrupt status block.
// Assumes a 32-bit Avalon-MM slave with byte addressing.
`ifndef EIS_CONSTS_SVH
`define EIS_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EIS_OFF_STATUS     8'h58
`define EIS_OFF_ENABLE     8'h5C
`define EIS_OFF_BYTE_TEST  8'h64
`define EIS_OFF_SW_CTRL    8'h80

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define EIS_BIT_SW         31
`define EIS_BIT_TXSTOP     25
`define EIS_BIT_RXSTOP     24
`define EIS_BIT_DROPMID    23
`define EIS_BIT_BUFDONE    21
`define EIS_BIT_RXDMA      20
`define EIS_BIT_TIMER      19
`define EIS_BIT_PHY        18
`define EIS_BIT_PME        17
`define EIS_BIT_TSOVF      16
`define EIS_BIT_OVERSIZE   15
`define EIS_BIT_RXERR      14
`define EIS_BIT_TXERR      13
`define EIS_BIT_TDUNDER    11
`define EIS_BIT_TDOVER     10
`define EIS_BIT_TDAVAIL    9
`define EIS_BIT_TSFULL     8
`define EIS_BIT_TSLEVEL    7
`define EIS_BIT_RXDROP     6
`define EIS_BIT_RDLEVEL    5
`define EIS_BIT_RSFULL     4
`define EIS_BIT_RSLEVEL    3

// ----------------------------------------
// Masks and reset values
// ----------------------------------------
// Bit 22 is reserved; bit 18 is writable as an enable but never cleared as a flag
`define EIS_IMPL_MASK      32'h83BFEFFF
`define EIS_W1C_MASK       32'h83BBEFFF
`define EIS_PHY_MASK       32'h00040000
`define EIS_STATUS_RESET   32'h00000000
`define EIS_ENABLE_RESET   32'h00000000
`define EIS_BYTE_TEST_VAL  32'h87654321
`define EIS_GPIO_W         3
`define EIS_OVERSIZE_BYTES 16'h0800

`endif

// *** logic/eis_pkg.sv ***
// Types for the Ethernet interrupt status block.
// Assumes eis_consts.svh is compiled alongside.
package eis_pkg;

  // ----------------------------------------
  // Bus slave phase
  // ----------------------------------------
  typedef enum logic [0:0] {
    EIS_IDLE,
    EIS_ACK
  } eis_bus_state_t;

endpackage : eis_pkg

// *** logic/eis_status.sv ***
// Interrupt status flags for an Ethernet controller with integrated PHY.
// Assumes source engines give one-cycle event pulses or levels on clk.
`timescale 1ns/1ps
`include "eis_consts.svh"

module eis_status (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Event sources, same clock
  input  wire logic        tx_stop_request,
  input  wire logic        tx_halted,
  input  wire logic        rx_halted,
  input  wire logic        drop_counter_msb,
  input  wire logic        buffer_loaded,
  input  wire logic        completion_notify_marker,
  input  wire logic        receive_dma_done,
  input  wire logic        timer_wrap,
  input  wire logic        phy_event,
  input  wire logic        power_event,
  input  wire logic        tx_status_overflow,
  input  wire logic [15:0] rx_frame_length,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_error,
  input  wire logic        tx_error,
  input  wire logic        tx_data_underrun,
  input  wire logic        tx_data_write,
  input  wire logic        tx_data_full,
  input  wire logic [7:0]  tx_free_space,
  input  wire logic [7:0]  tx_space_level,
  input  wire logic        tx_status_full,
  input  wire logic        tx_status_at_level,
  input  wire logic        rx_frame_dropped,
  input  wire logic        rx_data_at_level,
  input  wire logic        rx_status_full,
  input  wire logic        rx_status_at_level,
  input  wire logic [2:0]  pin_events,
  // Interrupt and wake
  output logic             master_interrupt,
  output logic             power_interrupt,
  output logic             wake_request
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic rising(input logic now, input logic last);
    rising = now & ~last;
  endfunction : rising

  // ----------------------------------------
  // State
  // ----------------------------------------
  eis_pkg::eis_bus_state_t bus_state;
  eis_pkg::eis_bus_state_t next_bus_state;
  logic [31:0]             interrupt_status_flags;
  logic [31:0]             interrupt_enable;
  logic                    software_request_enable;
  logic                    drop_msb_last;
  logic                    halted_last;
  logic                    rx_halted_last;
  logic [31:0]             event_vec;
  logic [31:0]             clear_vec;
  logic [31:0]             next_flags;
  logic [31:0]             read_mux;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire       access      = avs_read | avs_write;
  wire       take        = (bus_state == eis_pkg::EIS_ACK);
  wire       wr_take     = take & avs_write;
  wire       hit_status  = (avs_address == `EIS_OFF_STATUS);
  wire       hit_enable  = (avs_address == `EIS_OFF_ENABLE);
  wire       hit_bytest  = (avs_address == `EIS_OFF_BYTE_TEST);
  wire       hit_swctrl  = (avs_address == `EIS_OFF_SW_CTRL);
  wire [31:0] lanes      = lane_mask(avs_byteenable);

  // One wait state; request held by master until waitrequest low
  always_comb begin
    unique case (bus_state)
      eis_pkg::EIS_IDLE: next_bus_state = access ? eis_pkg::EIS_ACK : eis_pkg::EIS_IDLE;
      eis_pkg::EIS_ACK:  next_bus_state = eis_pkg::EIS_IDLE;
    endcase
  end

  assign avs_waitrequest = access & ~take;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_state <= eis_pkg::EIS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  always_comb begin
    event_vec                     = 32'h00000000;
    event_vec[`EIS_BIT_SW]        = software_request_enable;
    event_vec[`EIS_BIT_TXSTOP]    = tx_stop_request & rising(tx_halted, halted_last);
    event_vec[`EIS_BIT_RXSTOP]    = rising(rx_halted, rx_halted_last);
    event_vec[`EIS_BIT_DROPMID]   = rising(drop_counter_msb, drop_msb_last);
    event_vec[`EIS_BIT_BUFDONE]   = buffer_loaded & completion_notify_marker;
    event_vec[`EIS_BIT_RXDMA]     = receive_dma_done;
    event_vec[`EIS_BIT_TIMER]     = timer_wrap;
    event_vec[`EIS_BIT_PME]       = power_event;
    event_vec[`EIS_BIT_TSOVF]     = tx_status_overflow;
    event_vec[`EIS_BIT_OVERSIZE]  = rx_frame_end &
                                    (rx_frame_length > `EIS_OVERSIZE_BYTES);
    event_vec[`EIS_BIT_RXERR]     = rx_error;
    event_vec[`EIS_BIT_TXERR]     = tx_error;
    event_vec[`EIS_BIT_TDUNDER]   = tx_data_underrun;
    event_vec[`EIS_BIT_TDOVER]    = tx_data_write & tx_data_full;
    event_vec[`EIS_BIT_TDAVAIL]   = (tx_free_space > tx_space_level);
    event_vec[`EIS_BIT_TSFULL]    = tx_status_full;
    event_vec[`EIS_BIT_RSFULL]    = rx_status_full;
    event_vec[`EIS_BIT_TSLEVEL]   = tx_status_at_level;
    event_vec[`EIS_BIT_RDLEVEL]   = rx_data_at_level;
    event_vec[`EIS_BIT_RSLEVEL]   = rx_status_at_level;
    event_vec[`EIS_BIT_RXDROP]    = rx_frame_dropped;
    event_vec[`EIS_GPIO_W-1:0]    = pin_events;
  end

  // ----------------------------------------
  // Flag update
  // ----------------------------------------
  // Clear only on the accepting cycle, only enabled lanes
  assign clear_vec = (wr_take & hit_status) ?
                     (avs_writedata & lanes & `EIS_W1C_MASK) : 32'h00000000;

  // Set beats clear; PHY bit is a live copy, reserved bits forced low
  always_comb begin
    next_flags = ((interrupt_status_flags & ~clear_vec) | event_vec) & `EIS_W1C_MASK;
    next_flags[`EIS_BIT_PHY] = phy_event;
    next_flags = next_flags & `EIS_IMPL_MASK;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interrupt_status_flags <= `EIS_STATUS_RESET;
    end else begin
      interrupt_status_flags <= next_flags;
    end
  end

  // ----------------------------------------
  // Enable and software control
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interrupt_enable        <= `EIS_ENABLE_RESET;
      software_request_enable <= 1'b0;
    end else begin
      if (wr_take & hit_enable) begin
        interrupt_enable <= ((interrupt_enable & ~lanes) | (avs_writedata & lanes)) &
                            `EIS_IMPL_MASK;
      end
      if (wr_take & hit_swctrl & avs_byteenable[0]) begin
        software_request_enable <= avs_writedata[0];
      end
    end
  end

  // ----------------------------------------
  // Edge history
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      drop_msb_last  <= 1'b0;
      halted_last    <= 1'b0;
      rx_halted_last <= 1'b0;
    end else begin
      drop_msb_last  <= drop_counter_msb;
      halted_last    <= tx_halted;
      rx_halted_last <= rx_halted;
    end
  end

  // ----------------------------------------
  // Interrupt and wake outputs
  // ----------------------------------------
  // Master is the raw OR; any holdoff timer sits downstream of it
  assign master_interrupt = |(interrupt_status_flags & interrupt_enable);
  // Separate power path so a downstream holdoff cannot delay it
  assign power_interrupt  = interrupt_status_flags[`EIS_BIT_PME] &
                            interrupt_enable[`EIS_BIT_PME];

  // Wake pulse only from a byte test write, never from a power event
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= wr_take & hit_bytest;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    if (hit_status) begin
      read_mux = interrupt_status_flags;
    end else if (hit_enable) begin
      read_mux = interrupt_enable;
    end else if (hit_bytest) begin
      read_mux = `EIS_BYTE_TEST_VAL;
    end else if (hit_swctrl) begin
      read_mux = {31'h00000000, software_request_enable};
    end else begin
      read_mux = 32'h00000000;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~take) begin
      avs_readdata <= read_mux;
    end
  end

endmodule : eis_status

// *** tb/eis_status_asserts.sv ***
// Checker for the interrupt status block, bound to its top ports.
// Assumes one clock domain and the one-wait-state bus of the block.
`timescale 1ns/1ps
`include "eis_consts.svh"

module eis_status_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Sources and outputs
  input wire logic        phy_event,
  input wire logic        master_interrupt,
  input wire logic        power_interrupt,
  input wire logic        wake_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire logic rd_ack  = avs_read && !avs_waitrequest;
  wire logic wr_test = avs_write && !avs_waitrequest && avs_address == `EIS_OFF_BYTE_TEST;
  wire logic rd_sts  = rd_ack && avs_address == `EIS_OFF_STATUS;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_wait_once;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  property p_idle_nowait;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  property p_reserved;
    rd_sts |-> (avs_readdata & ~`EIS_IMPL_MASK) == 32'h0;
  endproperty
  property p_byte_test;
    rd_ack && avs_address == `EIS_OFF_BYTE_TEST |-> avs_readdata == `EIS_BYTE_TEST_VAL;
  endproperty
  property p_wake_cause;
    wr_test |=> wake_request;
  endproperty
  property p_wake_only;
    wake_request |-> $past(wr_test);
  endproperty
  property p_phy_copy;
    rd_sts |-> avs_readdata[18] == $past(phy_event, 2);
  endproperty
  property p_power_master;
    power_interrupt |-> master_interrupt;
  endproperty

  a_wait_once:    assert property (p_wait_once) else $error("waitrequest not one cycle");
  a_idle_nowait:  assert property (p_idle_nowait) else $error("waitrequest while idle");
  a_reserved:     assert property (p_reserved) else $error("reserved bit set");
  a_byte_test:    assert property (p_byte_test) else $error("byte test value");
  a_wake_cause:   assert property (p_wake_cause) else $error("wake missing");
  a_wake_only:    assert property (p_wake_only) else $error("stray wake");
  a_phy_copy:     assert property (p_phy_copy) else $error("phy bit stale");
  a_power_master: assert property (p_power_master) else $error("power not in master");

  c_wake:   cover property (wr_test);
  c_master: cover property (master_interrupt);
  c_phy:    cover property (rd_sts && avs_readdata[18]);
endmodule : eis_status_asserts

// *** tb/eis_status_tb.sv ***
// Self-checking bench for the interrupt status block.
// Assumes the block answers each bus request after one wait state.
`timescale 1ns/1ps
`include "eis_consts.svh"

module eis_status_tb;
  logic        clk, reset, avs_read, avs_write, mark_q, stop_q, full_q;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, src, rd;
  logic [3:0]  be;
  logic [15:0] flen;
  logic [31:0] w1c = `EIS_W1C_MASK;
  wire logic [31:0] avs_readdata;
  wire logic   avs_waitrequest, master_interrupt, power_interrupt, wake_request;
  int          err_total, cmp_count, cycles, wakes;

  eis_status DUT (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(be), .avs_readdata, .avs_waitrequest,
    .tx_stop_request(stop_q), .tx_halted(src[25]), .rx_halted(src[24]),
    .drop_counter_msb(src[23]), .buffer_loaded(src[21]), .completion_notify_marker(mark_q),
    .receive_dma_done(src[20]), .timer_wrap(src[19]), .phy_event(src[18]),
    .power_event(src[17]), .tx_status_overflow(src[16]), .rx_frame_length(flen),
    .rx_frame_end(src[15]), .rx_error(src[14]), .tx_error(src[13]),
    .tx_data_underrun(src[11]), .tx_data_write(src[10]), .tx_data_full(full_q),
    .tx_free_space({7'h08, src[9]}), .tx_space_level(8'h10), .tx_status_full(src[8]),
    .tx_status_at_level(src[7]), .rx_frame_dropped(src[6]), .rx_data_at_level(src[5]),
    .rx_status_full(src[4]), .rx_status_at_level(src[3]), .pin_events(src[2:0]),
    .master_interrupt, .power_interrupt, .wake_request
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n == 50) chk(32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic fire(input logic [31:0] m);
    @(posedge clk) src <= m;
    @(posedge clk) src <= 32'h0;
  endtask : fire

  // ----------------------------------------
  // Clock, timeout, wake count
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (wake_request === 1'b1) wakes++;
    if (cycles == 20000) begin
      $display("wrong value at %0t: timeout", $time);
      err_total++;
      conclude();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
    avs_writedata = 32'h0; be = 4'hF; src = 32'h0; flen = 16'h0801;
    mark_q = 1'b1; stop_q = 1'b1; full_q = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rchk(`EIS_OFF_STATUS, `EIS_STATUS_RESET);
    rchk(`EIS_OFF_ENABLE, `EIS_ENABLE_RESET);
    rchk(`EIS_OFF_BYTE_TEST, `EIS_BYTE_TEST_VAL);
    rchk(8'h10, 32'h0);
    // Enables are off here, so flags must latch anyway
    for (int b = 0; b < 31; b++) if (w1c[b] && b != `EIS_BIT_PHY) begin
      fire(32'h1 << b);
      rchk(`EIS_OFF_STATUS, 32'h1 << b);
      bus(1'b1, `EIS_OFF_STATUS, 32'h1 << b);
      rchk(`EIS_OFF_STATUS, 32'h0);
    end
    @(posedge clk) begin mark_q <= 1'b0; stop_q <= 1'b0; full_q <= 1'b0; flen <= 16'h0800; end
    fire(32'h02208400);
    rchk(`EIS_OFF_STATUS, 32'h0);
    bus(1'b1, `EIS_OFF_SW_CTRL, 32'h1);
    bus(1'b1, `EIS_OFF_SW_CTRL, 32'h0);
    rchk(`EIS_OFF_STATUS, 32'h80000000);
    bus(1'b1, `EIS_OFF_STATUS, 32'h80000000);
    rchk(`EIS_OFF_STATUS, 32'h0);
    @(posedge clk) src <= 32'h00040000;
    bus(1'b1, `EIS_OFF_STATUS, 32'hFFFFFFFF);
    rchk(`EIS_OFF_STATUS, 32'h00040000);
    @(posedge clk) src <= 32'h0;
    rchk(`EIS_OFF_STATUS, 32'h0);
    fire(32'h4040);
    bus(1'b1, `EIS_OFF_STATUS, 32'h0);
    rchk(`EIS_OFF_STATUS, 32'h4040);
    @(posedge clk) be <= 4'h1;
    bus(1'b1, `EIS_OFF_STATUS, 32'hFFFFFFFF);
    rchk(`EIS_OFF_STATUS, 32'h4000);
    @(posedge clk) be <= 4'hF;
    bus(1'b1, `EIS_OFF_STATUS, 32'h4000);
    bus(1'b1, `EIS_OFF_ENABLE, 32'h00020040);
    rchk(`EIS_OFF_ENABLE, 32'h00020040);
    fire(32'h20);
    @(negedge clk) chk({31'h0, master_interrupt}, 32'h0);
    fire(32'h40);
    @(negedge clk) chk({31'h0, master_interrupt}, 32'h1);
    fire(32'h00020000);
    @(negedge clk) chk({31'h0, power_interrupt}, 32'h1);
    bus(1'b1, `EIS_OFF_STATUS, 32'hFFFFFFFF);
    @(negedge clk) chk({30'h0, master_interrupt, power_interrupt}, 32'h0);
    // Event held across the clearing write must win
    @(posedge clk) src <= 32'h40;
    bus(1'b1, `EIS_OFF_STATUS, 32'h40);
    @(posedge clk) src <= 32'h0;
    rchk(`EIS_OFF_STATUS, 32'h40);
    bus(1'b1, `EIS_OFF_ENABLE, 32'hFFFFFFFF);
    rchk(`EIS_OFF_ENABLE, `EIS_IMPL_MASK);
    chk(wakes, 32'h0);
    bus(1'b1, `EIS_OFF_BYTE_TEST, 32'h12345678);
    rchk(`EIS_OFF_BYTE_TEST, `EIS_BYTE_TEST_VAL);
    chk(wakes, 32'h1);
    conclude();
  end
endmodule : eis_status_tb

bind eis_status eis_status_asserts u_chk (
  .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .phy_event, .master_interrupt, .power_interrupt, .wake_request
);
